/* File: include/dspi_defs.vh */
// Shared constants of the DRAM/SDRAM pin interface.
// Assumes inclusion by bare name from the design files.
`ifndef DSPI_DEFS_VH
`define DSPI_DEFS_VH

// ----------------------------------------------------------------
// Bus clock divide selection
// ----------------------------------------------------------------
`define DSPI_DIV_QUARTER 2'b00
`define DSPI_DIV_RSVD 2'b01
`define DSPI_DIV_HALF 2'b10
`define DSPI_DIV_THIRD 2'b11

// ----------------------------------------------------------------
// Bus clock counts: last count value and high phase length
// ----------------------------------------------------------------
`define DSPI_HALF_LAST 2'h1
`define DSPI_HALF_HIGH 2'h1
`define DSPI_THIRD_LAST 2'h2
`define DSPI_THIRD_HIGH 2'h2
`define DSPI_QUARTER_LAST 2'h3
`define DSPI_QUARTER_HIGH 2'h2

// ----------------------------------------------------------------
// Memory port width selection
// ----------------------------------------------------------------
`define DSPI_PORT_32 2'b00
`define DSPI_PORT_8 2'b01
`define DSPI_PORT_16 2'b10

// ----------------------------------------------------------------
// Sizes and timing counts
// ----------------------------------------------------------------
`define DSPI_ADDR_W 29
`define DSPI_LOOP_WIN 5'h10
`define DSPI_SYNC_FILL 2'h3

// ----------------------------------------------------------------
// Reset values of the pins (inactive) and of the bus clock divide counter
// ----------------------------------------------------------------
`define DSPI_RST_ROW_N 2'h3
`define DSPI_RST_COL_N 4'hf
`define DSPI_RST_CMD_N 1'b1
`define DSPI_RST_CKE 1'b0
`define DSPI_RST_WFLAG_N 1'b1
`define DSPI_RST_DIV_CNT 2'h3

`endif

/* File: logic/dspi_bus_clk_gen.v */
// Bus clock generator: divides the core clock by 2, 3 or 4.
// Assumes the divide selection is steady while out of reset.
`timescale 1ns/1ps
`default_nettype none
`include "dspi_defs.vh"

module dspi_bus_clk_gen (
  input wire core_clk_i,
  input wire rst_b_i,
  input wire [1:0] div_sel_i,
  output reg bus_clock_out_o,
  output wire rise_now_o,
  output wire fall_now_o
);

  reg [1:0] cnt;
  reg [1:0] last;
  reg [1:0] high;
  reg [1:0] next_cnt;
  reg next_clk;

  // ----------------------------------------------------------------
  // Divide ratio
  // ----------------------------------------------------------------
  always @* begin
    case (div_sel_i)
      `DSPI_DIV_HALF: begin
        last = `DSPI_HALF_LAST;
        high = `DSPI_HALF_HIGH;
      end
      `DSPI_DIV_THIRD: begin
        last = `DSPI_THIRD_LAST;
        high = `DSPI_THIRD_HIGH;
      end
      default: begin
        last = `DSPI_QUARTER_LAST;
        high = `DSPI_QUARTER_HIGH;
      end
    endcase
    next_cnt = (cnt >= last) ? 2'h0 : cnt + 2'h1;
    // High for the first counts of each period
    next_clk = (next_cnt < high);
  end

  assign rise_now_o = next_clk & ~bus_clock_out_o;
  assign fall_now_o = ~next_clk & bus_clock_out_o;

  always @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      // Last count, so the first high phase is full length
      cnt <= `DSPI_RST_DIV_CNT;
      bus_clock_out_o <= 1'b0;
    end else begin
      cnt <= next_cnt;
      bus_clock_out_o <= next_clk;
    end
  end

endmodule // dspi_bus_clk_gen
`default_nettype wire

/* File: logic/dspi_pin_interface.v */
// DRAM/SDRAM pin stage: registers strobes, masks and commands.
// Assumes the controller core drives the access fields on core_clk_i.
// What this block does
// - Supports external DRAM with 8, 16 or 32 bit data ports.
// - Addresses up to 512 Mbytes of external DRAM.
// - Two active-low row strobes, one per block; SDRAM chip selects.
// - Four active-low column strobes for an asynchronous DRAM block.
// - With SDRAM the column strobes act as per-byte data masks.
// - Column strobe 0 serves the most significant byte, 3 the least.
// - Write flag low through a write cycle, high for reads.
// - Synchronous row and column commands come from registers.
// - Synchronous clock enable comes from a register.
// - Edge select high: SDRAM outputs change on bus clock rise.
// - Edge select low: SDRAM outputs change on bus clock fall.
// - Looped-back SDRAM clock: outputs change on its rising edge.
// - Bus clock runs at half, third or quarter of core clock.
`timescale 1ns/1ps
`default_nettype none
`include "dspi_defs.vh"

module dspi_pin_interface #(
  parameter ADDR_W = `DSPI_ADDR_W
) (
  input wire core_clk_i,
  input wire rst_b_i,
  input wire [1:0] div_sel_i,
  input wire output_edge_select_i,
  input wire sdram_mode_i,
  input wire [1:0] port_width_i,
  input wire access_valid_i,
  input wire access_write_i,
  input wire access_block_i,
  input wire access_col_phase_i,
  input wire [3:0] access_byte_en_i,
  input wire [ADDR_W-1:0] access_addr_i,
  input wire cmd_row_n_i,
  input wire cmd_col_n_i,
  input wire clock_enable_i,
  output wire bus_clock_out_o,
  output wire pin_update_o,
  output wire loop_back_o,
  output reg [1:0] row_strobe_n_o,
  output reg [3:0] col_strobe_n_o,
  output reg mem_write_flag_n_o,
  output reg [ADDR_W-1:0] mem_addr_o,
  output reg sync_row_cmd_n_o,
  output reg sync_column_cmd_n_o,
  output reg sync_clock_enable_o
);

  // ----------------------------------------------------------------
  // Bus clock
  // ----------------------------------------------------------------
  wire rise_now;
  wire fall_now;

  dspi_bus_clk_gen u_clk_gen (
    .core_clk_i(core_clk_i),
    .rst_b_i(rst_b_i),
    .div_sel_i(div_sel_i),
    .bus_clock_out_o(bus_clock_out_o),
    .rise_now_o(rise_now),
    .fall_now_o(fall_now)
  );

  // ----------------------------------------------------------------
  // Edge select synchroniser and mode detect
  // ----------------------------------------------------------------
  reg es_meta;
  reg es_sync;
  reg es_prev;
  reg [1:0] es_fill;
  reg [4:0] toggle_age;
  reg loop_back;
  wire es_primed;
  wire es_toggle;

  // No compare until the stages hold real pin samples
  assign es_primed = (es_fill == `DSPI_SYNC_FILL);
  assign es_toggle = es_primed && (es_sync != es_prev);

  always @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      es_meta <= 1'b0;
      es_sync <= 1'b0;
      es_prev <= 1'b0;
      es_fill <= 2'h0;
      toggle_age <= `DSPI_LOOP_WIN;
      loop_back <= 1'b0;
    end else begin
      es_meta <= output_edge_select_i;
      es_sync <= es_meta;
      es_prev <= es_sync;
      if (!es_primed) begin
        es_fill <= es_fill + 2'h1;
      end
      // A toggling input is the looped-back clock, a steady one a strap
      if (es_toggle) begin
        toggle_age <= 5'h0;
        loop_back <= 1'b1;
      end else if (toggle_age != `DSPI_LOOP_WIN) begin
        toggle_age <= toggle_age + 5'h1;
      end else begin
        loop_back <= 1'b0;
      end
    end
  end

  assign loop_back_o = loop_back;

  // ----------------------------------------------------------------
  // Output update strobe
  // ----------------------------------------------------------------
  reg sdram_upd;

  always @* begin
    if (loop_back)
      sdram_upd = es_sync & ~es_prev;
    else if (es_sync)
      sdram_upd = rise_now;
    else
      sdram_upd = fall_now;
  end

  // Async DRAM always loads on the bus clock rise
  assign pin_update_o = sdram_mode_i ? sdram_upd : rise_now;

  // ----------------------------------------------------------------
  // Byte lane mapping
  // ----------------------------------------------------------------
  function [3:0] lane_map;
    input [3:0] be;
    input [1:0] width;
    begin
      // Lane 0 is the most significant byte
      lane_map = {be[0], be[1], be[2], be[3]};
      case (width)
        `DSPI_PORT_8: lane_map = lane_map & 4'h1;
        `DSPI_PORT_16: lane_map = lane_map & 4'h3;
        default: lane_map = lane_map;
      endcase
    end
  endfunction

  wire [3:0] lanes;
  assign lanes = lane_map(access_byte_en_i, port_width_i);

  // ----------------------------------------------------------------
  // Next pin values
  // ----------------------------------------------------------------
  reg [1:0] next_row_n;
  reg [3:0] next_col_n;
  reg next_write_n;
  reg next_cmd_row_n;
  reg next_cmd_col_n;
  reg next_cke;

  always @* begin
    next_row_n = `DSPI_RST_ROW_N;
    next_col_n = `DSPI_RST_COL_N;
    next_write_n = `DSPI_RST_WFLAG_N;
    if (access_valid_i) begin
      next_row_n[access_block_i] = 1'b0;
      next_write_n = ~access_write_i;
      if (sdram_mode_i)
        next_col_n = ~lanes;
      else if (access_col_phase_i)
        next_col_n = ~lanes;
    end
  end

  // ----------------------------------------------------------------
  // Next SDRAM command values
  // ----------------------------------------------------------------
  // Async DRAM leaves the command pins idle
  always @* begin
    next_cmd_row_n = `DSPI_RST_CMD_N;
    next_cmd_col_n = `DSPI_RST_CMD_N;
    next_cke = `DSPI_RST_CKE;
    if (sdram_mode_i) begin
      next_cmd_row_n = cmd_row_n_i;
      next_cmd_col_n = cmd_col_n_i;
      next_cke = clock_enable_i;
    end
  end

  // ----------------------------------------------------------------
  // Strobe, write flag and address registers
  // ----------------------------------------------------------------
  always @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      row_strobe_n_o <= `DSPI_RST_ROW_N;
      col_strobe_n_o <= `DSPI_RST_COL_N;
      mem_write_flag_n_o <= `DSPI_RST_WFLAG_N;
      mem_addr_o <= {ADDR_W{1'b0}};
    end else if (pin_update_o) begin
      row_strobe_n_o <= next_row_n;
      col_strobe_n_o <= next_col_n;
      mem_write_flag_n_o <= next_write_n;
      mem_addr_o <= access_addr_i;
    end
  end

  // ----------------------------------------------------------------
  // SDRAM command registers
  // ----------------------------------------------------------------
  always @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sync_row_cmd_n_o <= `DSPI_RST_CMD_N;
      sync_column_cmd_n_o <= `DSPI_RST_CMD_N;
      sync_clock_enable_o <= `DSPI_RST_CKE;
    end else if (pin_update_o) begin
      sync_row_cmd_n_o <= next_cmd_row_n;
      sync_column_cmd_n_o <= next_cmd_col_n;
      sync_clock_enable_o <= next_cke;
    end
  end

endmodule // dspi_pin_interface
`default_nettype wire

/* File: sim/dspi_mem_model.sv */
// Memory-side model: gives edge select as a strap or a loop-back clock.
// Assumes the bench picks strap or loop-back only while in reset.
`timescale 1ns/1ps
`default_nettype none
module dspi_mem_model (
  input wire logic bus_clock_i,
  input wire logic loop_en_i,
  input wire logic strap_i,
  output wire logic edge_sel_o
);
  // Buffered clock: same rate, slight delay
  assign #2 edge_sel_o = loop_en_i ? bus_clock_i : strap_i;
endmodule // dspi_mem_model
`default_nettype wire

/* File: sim/dspi_pin_asserts.sv */
// Checker of the DRAM/SDRAM pin stage, bound to its top module.
// Assumes divide and edge strap change only in reset.
`timescale 1ns/1ps
`default_nettype none
module dspi_pin_asserts (
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic [1:0] div_sel_i,
  input wire logic output_edge_select_i,
  input wire logic sdram_mode_i,
  input wire logic access_valid_i,
  input wire logic access_write_i,
  input wire logic access_block_i,
  input wire logic [3:0] access_byte_en_i,
  input wire logic cmd_row_n_i,
  input wire logic cmd_col_n_i,
  input wire logic clock_enable_i,
  input wire logic bus_clock_out_o,
  input wire logic pin_update_o,
  input wire logic loop_back_o,
  input wire logic [1:0] row_strobe_n_o,
  input wire logic [3:0] col_strobe_n_o,
  input wire logic mem_write_flag_n_o,
  input wire logic sync_row_cmd_n_o,
  input wire logic sync_column_cmd_n_o,
  input wire logic sync_clock_enable_o
);
  logic [2:0] age;
  wire logic settled = age == 3'h7;
  wire logic upd_s = pin_update_o && sdram_mode_i;
  // Edge choice follows the synced strap a few cycles after reset
  always @(posedge core_clk_i or negedge rst_b_i)
    if (!rst_b_i) age <= 3'h0;
    else if (!settled) age <= age + 3'h1;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);
  sequence s_half;
    bus_clock_out_o ##1 !bus_clock_out_o ##1 bus_clock_out_o;
  endsequence
  sequence s_third;
    bus_clock_out_o[*2] ##1 !bus_clock_out_o ##1 bus_clock_out_o;
  endsequence
  AST_HOLD: assert property (!pin_update_o |=> $stable({row_strobe_n_o,
    col_strobe_n_o, mem_write_flag_n_o})) else $error("pins moved early");
  AST_MASK: assert property (upd_s && access_valid_i
    |=> col_strobe_n_o[0] == !$past(access_byte_en_i[3])) else $error("mask");
  AST_WRITE: assert property (pin_update_o && access_valid_i
    |=> mem_write_flag_n_o == !$past(access_write_i)) else $error("write flag");
  AST_ROW: assert property (pin_update_o && access_valid_i
    |=> row_strobe_n_o == ~(2'b01 << $past(access_block_i))) else $error("row");
  AST_CMD: assert property (upd_s |=> sync_row_cmd_n_o == $past(cmd_row_n_i)
    && sync_column_cmd_n_o == $past(cmd_col_n_i)) else $error("commands");
  AST_CKE: assert property (upd_s
    |=> sync_clock_enable_o == $past(clock_enable_i)) else $error("cke");
  AST_RISE: assert property (upd_s && settled && !loop_back_o &&
    output_edge_select_i |=> bus_clock_out_o) else $error("not on rise");
  AST_FALL: assert property (upd_s && settled && !loop_back_o &&
    !output_edge_select_i |=> !bus_clock_out_o) else $error("not on fall");
  AST_HALF: assert property ($rose(bus_clock_out_o) && div_sel_i == 2'b10
    |-> s_half) else $error("half ratio");
  AST_THIRD: assert property ($rose(bus_clock_out_o) && div_sel_i == 2'b11
    |-> s_third) else $error("third ratio");
  AST_LOOP: assert property (loop_back_o && sdram_mode_i &&
    $rose(bus_clock_out_o) |-> ##2 pin_update_o) else $error("loop edge");
endmodule // dspi_pin_asserts
`default_nettype wire

/* File: sim/tb.sv */
// Self-checking bench of the DRAM/SDRAM pin stage.
// Assumes the design, memory model and checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic core_clk_i = 0, rst_b_i = 0, loop_en = 0, strap = 1;
  logic sdram_mode_i = 1, access_valid_i = 0, access_write_i = 0;
  logic access_block_i = 0, access_col_phase_i = 0, clock_enable_i = 0;
  logic cmd_row_n_i = 1, cmd_col_n_i = 1;
  logic [1:0] div_sel_i = 2'b10, port_width_i = 2'b00;
  logic [3:0] access_byte_en_i = 4'h0;
  logic [28:0] access_addr_i = 29'h0;
  wire output_edge_select_i, bus_clock_out_o, pin_update_o, loop_back_o;
  wire mem_write_flag_n_o, sync_row_cmd_n_o, sync_column_cmd_n_o;
  wire sync_clock_enable_o;
  wire [1:0] row_strobe_n_o;
  wire [3:0] col_strobe_n_o;
  wire [28:0] mem_addr_o;
  int n_mismatch = 0, total_checks = 0;
  always #4 core_clk_i = ~core_clk_i;
  dspi_pin_interface DUT (
    .core_clk_i(core_clk_i),
    .rst_b_i(rst_b_i),
    .div_sel_i(div_sel_i),
    .output_edge_select_i(output_edge_select_i),
    .sdram_mode_i(sdram_mode_i),
    .port_width_i(port_width_i),
    .access_valid_i(access_valid_i),
    .access_write_i(access_write_i),
    .access_block_i(access_block_i),
    .access_col_phase_i(access_col_phase_i),
    .access_byte_en_i(access_byte_en_i),
    .access_addr_i(access_addr_i),
    .cmd_row_n_i(cmd_row_n_i),
    .cmd_col_n_i(cmd_col_n_i),
    .clock_enable_i(clock_enable_i),
    .bus_clock_out_o(bus_clock_out_o),
    .pin_update_o(pin_update_o),
    .loop_back_o(loop_back_o),
    .row_strobe_n_o(row_strobe_n_o),
    .col_strobe_n_o(col_strobe_n_o),
    .mem_write_flag_n_o(mem_write_flag_n_o),
    .mem_addr_o(mem_addr_o),
    .sync_row_cmd_n_o(sync_row_cmd_n_o),
    .sync_column_cmd_n_o(sync_column_cmd_n_o),
    .sync_clock_enable_o(sync_clock_enable_o)
  );
  dspi_mem_model MEM (.bus_clock_i(bus_clock_out_o), .loop_en_i(loop_en),
    .strap_i(strap), .edge_sel_o(output_edge_select_i));
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic restart(logic [1:0] d, logic s, logic st, logic lp);
    @(posedge core_clk_i);
    rst_b_i <= 0; div_sel_i <= d; sdram_mode_i <= s; strap <= st; loop_en <= lp;
    repeat (3) @(posedge core_clk_i);
    rst_b_i <= 1;
    repeat (24) @(posedge core_clk_i);
  endtask
  task automatic load();
    @(posedge core_clk_i);
    for (int i = 0; i < 50 && pin_update_o !== 1'b1; i++) @(posedge core_clk_i);
    if (pin_update_o !== 1'b1) begin n_mismatch++; end_of_test(); end
    #1;
  endtask
  task automatic access(logic w, logic b, logic [3:0] e, logic [1:0] pw);
    @(posedge core_clk_i);
    access_valid_i <= 1; access_write_i <= w; access_block_i <= b;
    access_byte_en_i <= e; port_width_i <= pw; access_col_phase_i <= 1;
    cmd_row_n_i <= w; cmd_col_n_i <= !w; clock_enable_i <= 1;
    access_addr_i <= {25'h0, e};
    load();
  endtask
  function automatic logic [3:0] lanes(logic [3:0] e, logic [1:0] pw);
    return {~e[0], ~e[1], ~e[2], ~e[3]} |
      (pw == 2'b01 ? 4'he : pw == 2'b10 ? 4'hc : 4'h0);
  endfunction
  task automatic t_sdram_lanes();
    logic [3:0] tbl [4] = '{4'h1, 4'h6, 4'h9, 4'hc};
    restart(2'b10, 1, 1, 0);
    for (int p = 0; p < 3; p++)
      foreach (tbl[j]) begin
        access(tbl[j][0], tbl[j][1], tbl[j], p[1:0]);
        check("mask", col_strobe_n_o, lanes(tbl[j], p[1:0]));
        check("row", row_strobe_n_o, tbl[j][1] ? 2'b01 : 2'b10);
        check("wflag", mem_write_flag_n_o, !tbl[j][0]);
        check("cmds", {sync_row_cmd_n_o, sync_column_cmd_n_o, sync_clock_enable_o},
          {tbl[j][0], !tbl[j][0], 1'b1});
        check("addr", mem_addr_o, tbl[j]);
        check("rise", bus_clock_out_o, 1);
      end
  endtask
  task automatic t_edge_low();
    restart(2'b11, 1, 0, 0);
    access(1, 0, 4'hf, 2'b00);
    check("fall", bus_clock_out_o, 0);
    check("mask all", col_strobe_n_o, 4'h0);
  endtask
  task automatic t_async();
    restart(2'b00, 0, 0, 0);
    access(1, 1, 4'hc, 2'b10);
    check("col", col_strobe_n_o, 4'hc);
    check("async rise", bus_clock_out_o, 1);
    check("idle cmds", {sync_row_cmd_n_o, sync_column_cmd_n_o,
      sync_clock_enable_o}, 3'b110);
    check("async row", row_strobe_n_o, 2'b01);
    check("async wflag", mem_write_flag_n_o, 0);
    @(posedge core_clk_i);
    access_col_phase_i <= 0;
    load();
    check("col off", col_strobe_n_o, 4'hf);
  endtask
  task automatic t_loop();
    restart(2'b10, 1, 0, 1);
    check("loop", loop_back_o, 1);
    access(0, 1, 4'h9, 2'b00);
    check("loop row", row_strobe_n_o, 2'b01);
    check("loop mask", col_strobe_n_o, lanes(4'h9, 2'b00));
  endtask
  task automatic t_period();
    int n;
    logic prev;
    for (int k = 0; k < 4; k++) begin
      restart(k[1:0], 1, 1, 0);
      #1;
      prev = bus_clock_out_o;
      n = 0;
      repeat (12) begin
        @(posedge core_clk_i);
        #1;
        n += int'(bus_clock_out_o && !prev);
        prev = bus_clock_out_o;
      end
      check("rises", n, k == 2 ? 6 : k == 3 ? 4 : 3);
    end
  endtask
  initial begin
    t_sdram_lanes();
    t_edge_low();
    t_async();
    t_loop();
    t_period();
    end_of_test();
  end
endmodule // tb
bind dspi_pin_interface dspi_pin_asserts CHK (
  .core_clk_i(core_clk_i),
  .rst_b_i(rst_b_i),
  .div_sel_i(div_sel_i),
  .output_edge_select_i(output_edge_select_i),
  .sdram_mode_i(sdram_mode_i),
  .access_valid_i(access_valid_i),
  .access_write_i(access_write_i),
  .access_block_i(access_block_i),
  .access_byte_en_i(access_byte_en_i),
  .cmd_row_n_i(cmd_row_n_i),
  .cmd_col_n_i(cmd_col_n_i),
  .clock_enable_i(clock_enable_i),
  .bus_clock_out_o(bus_clock_out_o),
  .pin_update_o(pin_update_o),
  .loop_back_o(loop_back_o),
  .row_strobe_n_o(row_strobe_n_o),
  .col_strobe_n_o(col_strobe_n_o),
  .mem_write_flag_n_o(mem_write_flag_n_o),
  .sync_row_cmd_n_o(sync_row_cmd_n_o),
  .sync_column_cmd_n_o(sync_column_cmd_n_o),
  .sync_clock_enable_o(sync_clock_enable_o)
);
`default_nettype wire
